// ---- rar_calendar.sv ----
// Purpose: BCD time and date counter behind the value registers.
// Assumes: One clock; sec_tick is a one-cycle pulse on that clock.
// Notes: The time and date fields have no reset, so they read unknown until written.
`timescale 1ns/10ps
`default_nettype none

module rar_calendar
  import rar_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sec_tick,
  input wire logic time_wr,
  input wire logic date_wr,
  input wire logic [31:0] time_wdata,
  input wire logic [31:0] date_wdata,
  output rar_time_t time_q,
  output rar_date_t date_q
);
  rar_time_t next_time;
  rar_date_t next_date;
  logic [8:0] sec_s, min_s, hour_s, day_s, mon_s, year_s;
  logic leap;
  logic [7:0] month_bcd;
  logic [7:0] last_day;

  assign month_bcd = {3'h0, date_q.months_tens, date_q.months_units};
  assign leap = date_q.years_tens[0] ?
                (date_q.years_units == 4'h2 || date_q.years_units == 4'h6) :
                (date_q.years_units == 4'h0 || date_q.years_units == 4'h4 ||
                 date_q.years_units == 4'h8);
  assign last_day = (month_bcd == 8'h02) ? (leap ? 8'h29 : 8'h28) :
                    (month_bcd == 8'h04 || month_bcd == 8'h06 || month_bcd == 8'h09 ||
                     month_bcd == 8'h11) ? 8'h30 : 8'h31;

  // Decimal carries ripple seconds to minutes to hours to days to months to years.
  assign sec_s = rar_bcd_step({1'b0, time_q.seconds_tens, time_q.seconds_units}, 8'h59, 8'h00); // RULE16
  assign min_s = rar_bcd_step({1'b0, time_q.minutes_tens, time_q.minutes_units}, 8'h59, 8'h00);
  assign hour_s = rar_bcd_step({2'h0, time_q.hours_tens, time_q.hours_units}, 8'h23, 8'h00);
  assign day_s = rar_bcd_step({2'h0, date_q.days_tens, date_q.days_units}, last_day, 8'h01);
  assign mon_s = rar_bcd_step(month_bcd, 8'h12, 8'h01);
  assign year_s = rar_bcd_step({date_q.years_tens, date_q.years_units}, 8'h99, 8'h00);

  always_comb
  begin
    next_time = time_q;
    next_date = date_q;
    next_time.seconds_tens = sec_s[6:4];
    next_time.seconds_units = sec_s[3:0];
    if (sec_s[8])
    begin
      next_time.minutes_tens = min_s[6:4];
      next_time.minutes_units = min_s[3:0];
    end
    if (sec_s[8] && min_s[8])
    begin
      next_time.hours_tens = hour_s[5:4];
      next_time.hours_units = hour_s[3:0];
    end
    if (sec_s[8] && min_s[8] && hour_s[8])
    begin
      next_date.days_tens = day_s[5:4];
      next_date.days_units = day_s[3:0];
      next_date.weekday_digit = (date_q.weekday_digit == 3'h6) ? 3'h0 :
                                date_q.weekday_digit + 3'h1;
      if (day_s[8])
      begin
        next_date.months_tens = mon_s[4];
        next_date.months_units = mon_s[3:0];
        if (mon_s[8])
        begin
          next_date.years_tens = year_s[7:4];
          next_date.years_units = year_s[3:0];
        end
      end
    end
  end

  // Unused bit positions are forced to zero on every write and carried unchanged by second ticks.
  always_ff @(posedge ref_clk)
  begin
    if (time_wr)
      time_q <= rar_time_t'(time_wdata & TIME_MASK); // RULE8 RULE9 RULE10 RULE11
    else if (sec_tick)
      time_q <= next_time;
  end

  always_ff @(posedge ref_clk)
  begin
    if (date_wr)
      date_q <= rar_date_t'(date_wdata & DATE_MASK); // RULE13
    else if (sec_tick)
      date_q <= next_date;
  end
endmodule : rar_calendar

`default_nettype wire

// ---- rar_alarm_repeat.sv ----
// Purpose: Shared constants and types; alarm repeat counter and value registers on Avalon-MM.
// Assumes: alarm_match is a one-cycle pulse from the neighbouring alarm comparator.
// Notes: Alarm and clock control reset only on por_n; time and date have no reset; everything else on rst_n.
// Behaviour
// RULE1 - Repeat count plus one gives the number of alarm firings.
// RULE2 - Each alarm event decrements the repeat count by one.
// RULE3 - At zero the count wraps to all ones only when chime is on.
// RULE4 - An event at zero with chime off clears the alarm arm bit.
// RULE5 - Software avoids writing alarm fields while enabled and read-unsafe is set.
// RULE6 - Software finishes a read-unsafe guarded read within 32 bus clock cycles.
// RULE7 - Alarm control returns to defaults only on power-on reset.
// RULE8 - Hours tens in bits 29-28, hours units in bits 27-24.
// RULE9 - Minutes tens in bits 22-20, minutes units in bits 19-16.
// RULE10 - Seconds tens in bits 14-12, seconds units in bits 11-8.
// RULE11 - Unused time bits 31-30, 23, 15 and 7-0 read zero.
// RULE12 - Time writes take effect only while value write unlock is set.
// RULE13 - Date holds year, month, day digits and weekday at fixed positions.
// RULE14 - With value write unlock clear, time and date writes are blocked.
// RULE15 - Read-unsafe is clear only beyond 32 cycles from a half-second rollover.
// RULE16 - Time and date start unknown and advance with decimal carries each second.
// RULE17 - Alarm events occur only while armed; only they decrement or disarm.
//
// Design decisions made here: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

package rar_pkg;
  localparam logic [4:0] ADDR_CLOCK_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_ALARM_CONTROL = 5'h04;
  localparam logic [4:0] ADDR_TIME_VALUE = 5'h08;
  localparam logic [4:0] ADDR_DATE_VALUE = 5'h0C;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h10;
  localparam logic [4:0] ADDR_IRQ_MASK = 5'h14;
  localparam int CTL_ENABLE_BIT = 15;
  localparam int CTL_UNLOCK_BIT = 3;
  localparam int CTL_UNSAFE_BIT = 2;
  localparam int CTL_HALF_SEC_BIT = 1;
  localparam int ALM_ARM_BIT = 15;
  localparam int ALM_CHIME_BIT = 14;
  localparam int ALM_PULSE_INIT_BIT = 13;
  localparam int ALM_UNSAFE_BIT = 12;
  localparam int ALM_MASK_LSB = 8;
  localparam int ALM_REPEAT_LSB = 0;
  localparam logic [31:0] TIME_MASK = 32'h3F7F7F00;
  localparam logic [31:0] DATE_MASK = 32'hFF1F3F07;
  localparam logic [31:0] SECONDS_MASK = 32'h00007F00;
  localparam int IRQ_ALARM_BIT = 0;
  localparam int IRQ_SECOND_BIT = 1;
  localparam int IRQ_DISARM_BIT = 2;
  localparam int IRQ_WIDTH = 3;
  localparam logic [7:0] REPEAT_MAX = 8'hFF;
  localparam int CLK_PERIOD_NS = 10;
  localparam int HALF_SEC_MS = 500;
  localparam int HALF_SEC_CYCLES_DEF = HALF_SEC_MS * 1000000 / CLK_PERIOD_NS;
  localparam int UNSAFE_WINDOW_CYCLES = 32;

  typedef struct packed {
    logic [1:0] pad_top;
    logic [1:0] hours_tens;
    logic [3:0] hours_units;
    logic pad_hours;
    logic [2:0] minutes_tens;
    logic [3:0] minutes_units;
    logic pad_minutes;
    logic [2:0] seconds_tens;
    logic [3:0] seconds_units;
    logic [7:0] pad_low;
  } rar_time_t;

  typedef struct packed {
    logic [3:0] years_tens;
    logic [3:0] years_units;
    logic [2:0] pad_year;
    logic months_tens;
    logic [3:0] months_units;
    logic [1:0] pad_month;
    logic [1:0] days_tens;
    logic [3:0] days_units;
    logic [4:0] pad_day;
    logic [2:0] weekday_digit;
  } rar_date_t;

  typedef struct packed {
    logic alarm_arm;
    logic chime;
    logic pulse_init;
    logic [3:0] match_mask;
    logic [7:0] alarm_repeat_count;
  } rar_alarm_t;

  // Steps a two-digit BCD value; bit 8 flags the wrap from last back to first.
  function automatic logic [8:0] rar_bcd_step(input logic [7:0] v, input logic [7:0] last,
                                              input logic [7:0] first);
    if (v == last)
      return {1'b1, first};
    else if (v[3:0] == 4'h9)
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    else
      return {1'b0, v[7:4], v[3:0] + 4'h1};
  endfunction : rar_bcd_step
endpackage : rar_pkg

module rar_alarm_repeat
  import rar_pkg::*;
#(
  parameter int HALF_SEC_CYCLES = HALF_SEC_CYCLES_DEF
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic alarm_match,
  output logic irq
);
  // Byte-lane merge of a write into the current contents of a register.
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] data,
                                           input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (data & m);
  endfunction : be_merge

  rar_alarm_t alarm;
  rar_alarm_t next_alarm;
  rar_time_t time_q;
  rar_date_t date_q;
  logic clk_enable;
  logic value_write_unlock;
  logic half_sec;
  logic [31:0] presc;
  logic [IRQ_WIDTH-1:0] irq_status;
  logic [IRQ_WIDTH-1:0] irq_mask;

  // Bus decode.
  wire bus_req = avs_read || avs_write;
  wire wr_hit = avs_write && !avs_waitrequest;
  wire hit_ctl = (avs_address == ADDR_CLOCK_CONTROL);
  wire hit_alm = (avs_address == ADDR_ALARM_CONTROL);
  wire hit_time = (avs_address == ADDR_TIME_VALUE);
  wire hit_date = (avs_address == ADDR_DATE_VALUE);
  wire hit_sts = (avs_address == ADDR_IRQ_STATUS);
  wire hit_msk = (avs_address == ADDR_IRQ_MASK);
  wire wr_ctl = wr_hit && hit_ctl;
  wire wr_alm = wr_hit && hit_alm;
  wire wr_time = wr_hit && hit_time && value_write_unlock; // RULE12 RULE14
  wire wr_date = wr_hit && hit_date && value_write_unlock; // RULE14
  wire wr_sts = wr_hit && hit_sts;
  wire wr_msk = wr_hit && hit_msk;
  wire [31:0] be_mask = be_merge(32'h00000000, 32'hFFFFFFFF, avs_byteenable);
  wire wr_seconds = wr_time && ((be_mask & SECONDS_MASK) != 32'h00000000);

  // Prescaler and the read-unsafe window ahead of each half-second rollover.
  wire half_tick = clk_enable && (presc == 32'(HALF_SEC_CYCLES - 1));
  wire sec_tick = half_tick && half_sec;
  wire [31:0] to_rollover = 32'(HALF_SEC_CYCLES) - presc;
  wire alarm_read_unsafe = clk_enable && (to_rollover <= 32'(UNSAFE_WINDOW_CYCLES)); // RULE15

  // Alarm events need the arm bit and a running clock.
  wire alarm_event = alarm_match && alarm.alarm_arm && clk_enable; // RULE17
  wire repeat_zero = (alarm.alarm_repeat_count == 8'h00);
  wire auto_disarm = alarm_event && repeat_zero && !alarm.chime; // RULE4

  // Register read words.
  wire [31:0] ctl_word = (32'(clk_enable) << CTL_ENABLE_BIT) |
                         (32'(value_write_unlock) << CTL_UNLOCK_BIT) |
                         (32'(alarm_read_unsafe) << CTL_UNSAFE_BIT) |
                         (32'(half_sec) << CTL_HALF_SEC_BIT);
  wire [31:0] alm_word = (32'(alarm.alarm_arm) << ALM_ARM_BIT) |
                         (32'(alarm.chime) << ALM_CHIME_BIT) |
                         (32'(alarm.pulse_init) << ALM_PULSE_INIT_BIT) |
                         (32'(alarm_read_unsafe) << ALM_UNSAFE_BIT) |
                         (32'(alarm.match_mask) << ALM_MASK_LSB) |
                         (32'(alarm.alarm_repeat_count) << ALM_REPEAT_LSB);
  wire [31:0] read_word = hit_ctl ? ctl_word :
                          hit_alm ? alm_word :
                          hit_time ? (32'(time_q) & TIME_MASK) : // RULE11
                          hit_date ? (32'(date_q) & DATE_MASK) :
                          hit_sts ? 32'(irq_status) :
                          hit_msk ? 32'(irq_mask) : 32'h00000000;
  wire [31:0] ctl_merged = be_merge(ctl_word, avs_writedata, avs_byteenable);
  wire [31:0] alm_merged = be_merge(alm_word, avs_writedata, avs_byteenable);
  wire [31:0] time_merged = be_merge(32'(time_q), avs_writedata, avs_byteenable);
  wire [31:0] date_merged = be_merge(32'(date_q), avs_writedata, avs_byteenable);
  wire [IRQ_WIDTH-1:0] sts_clear = wr_sts ? IRQ_WIDTH'(avs_writedata & be_mask) : '0;
  wire [IRQ_WIDTH-1:0] sts_set = IRQ_WIDTH'((32'(alarm_event) << IRQ_ALARM_BIT) |
                                            (32'(sec_tick) << IRQ_SECOND_BIT) |
                                            (32'(auto_disarm) << IRQ_DISARM_BIT));
  wire [IRQ_WIDTH-1:0] next_status = (irq_status & ~sts_clear) | sts_set;
  wire [IRQ_WIDTH-1:0] next_mask = wr_msk ? IRQ_WIDTH'(avs_writedata & be_mask) : irq_mask;

  // A hardware event wins over a software write landing in the same cycle.
  always_comb
  begin
    next_alarm = alarm;
    if (alarm_event)
    begin
      if (!repeat_zero)
        next_alarm.alarm_repeat_count = alarm.alarm_repeat_count - 8'h01; // RULE1 RULE2
      else if (alarm.chime)
        next_alarm.alarm_repeat_count = REPEAT_MAX; // RULE3
      if (auto_disarm)
        next_alarm.alarm_arm = 1'b0; // RULE4
    end
    else if (wr_alm)
    begin
      next_alarm.alarm_arm = alm_merged[ALM_ARM_BIT];
      next_alarm.chime = alm_merged[ALM_CHIME_BIT];
      if (!alarm.alarm_arm)
        next_alarm.pulse_init = alm_merged[ALM_PULSE_INIT_BIT];
      next_alarm.match_mask = alm_merged[ALM_MASK_LSB +: 4];
      next_alarm.alarm_repeat_count = alm_merged[ALM_REPEAT_LSB +: 8];
    end
  end

  // Only power-on reset touches the alarm and clock control state.
  always_ff @(posedge ref_clk)
  begin
    if (!por_n)
      alarm <= '0; // RULE7
    else
      alarm <= next_alarm;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!por_n)
    begin
      clk_enable <= 1'b0;
      value_write_unlock <= 1'b0;
    end
    else if (wr_ctl)
    begin
      if (value_write_unlock)
        clk_enable <= ctl_merged[CTL_ENABLE_BIT];
      value_write_unlock <= ctl_merged[CTL_UNLOCK_BIT];
    end
  end

  // A seconds write restarts the second so the new value holds a full second.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || wr_seconds || half_tick)
      presc <= 32'h00000000;
    else if (clk_enable)
      presc <= presc + 32'h00000001;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || wr_seconds)
      half_sec <= 1'b0;
    else if (half_tick)
      half_sec <= !half_sec;
  end

  rar_calendar u_calendar (
    .ref_clk(ref_clk),
    .sec_tick(sec_tick),
    .time_wr(wr_time),
    .date_wr(wr_date),
    .time_wdata(time_merged),
    .date_wdata(date_merged),
    .time_q(time_q),
    .date_q(date_q)
  );

  // Status bits are sticky; a set in the clearing cycle survives.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      irq_status <= '0;
      irq_mask <= '0;
      irq <= 1'b0;
    end
    else
    begin
      irq_status <= next_status;
      irq_mask <= next_mask;
      irq <= |(next_status & next_mask);
    end
  end

  // One wait cycle per access: data is latched on the same edge that waitrequest drops for one cycle.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end
    else
    begin
      avs_waitrequest <= !(bus_req && avs_waitrequest);
      if (avs_read && avs_waitrequest)
        avs_readdata <= read_word;
    end
  end

  a_repeat_decrement: assert property (@(posedge ref_clk) disable iff (!por_n)
    alarm_event && !repeat_zero |=> alarm.alarm_repeat_count == $past(alarm.alarm_repeat_count) - 8'h01) // RULE2
    else $error("repeat count did not decrement");

  a_repeat_wrap: assert property (@(posedge ref_clk) disable iff (!por_n)
    alarm_event && repeat_zero && alarm.chime |=> alarm.alarm_repeat_count == 8'hFF && alarm.alarm_arm) // RULE3
    else $error("repeat count did not wrap with chime");

  a_disarm_at_zero: assert property (@(posedge ref_clk) disable iff (!por_n)
    alarm_event && repeat_zero && !alarm.chime |=> alarm.alarm_repeat_count == 8'h00 && !alarm.alarm_arm) // RULE4
    else $error("alarm not disarmed at zero count");

  a_unarmed_quiet: assert property (@(posedge ref_clk) disable iff (!por_n)
    !alarm.alarm_arm && !wr_alm |=> $stable(alarm.alarm_repeat_count) && !alarm.alarm_arm) // RULE17
    else $error("unarmed alarm changed its state");

  a_por_only_reset: assert property (@(posedge ref_clk) disable iff (!por_n)
    !rst_n && !alarm_event && !wr_alm |=> $stable(alarm)) // RULE7
    else $error("alarm control changed under plain reset");

  a_time_locked: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_hit && (hit_time || hit_date) && !value_write_unlock && !sec_tick |=> $stable(time_q) && $stable(date_q)) // RULE12
    else $error("locked value register accepted a write");

  a_time_zero_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
    avs_read && avs_waitrequest && hit_time |=> (avs_readdata & ~TIME_MASK) == 32'h00000000) // RULE11
    else $error("unused time bits read non-zero");

  a_unsafe_window: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !alarm_read_unsafe && !wr_seconds |-> !half_tick [*8]) // RULE15
    else $error("rollover inside read-safe window");

  a_bus_answer: assert property (@(posedge ref_clk) disable iff (!rst_n)
    bus_req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle after request");

  a_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ##1 irq == |(irq_status & irq_mask))
    else $error("interrupt out of step with status and mask");

  a_status_set_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
    alarm_event && wr_sts && avs_writedata[IRQ_ALARM_BIT] |=> irq_status[IRQ_ALARM_BIT])
    else $error("alarm status lost to a same-cycle clear");
endmodule : rar_alarm_repeat

`default_nettype wire

// ---- test_rar_alarm_repeat.sv ----
// Purpose: Self-checking bench for the alarm repeat counter and time/date registers.
// Assumes: A short half-second count so that seconds tick within a short run.
// Notes: Reads queue their expected value; a monitor compares when the data lands.
`timescale 1ns/10ps
`default_nettype none

module test_rar_alarm_repeat
  import rar_pkg::*;
;
  localparam int HS = 64;
  localparam int LIMIT = 20000;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  localparam logic [31:0] ACMP = 32'hFFFFCFFF;
  localparam logic [31:0] UNL = 32'h1 << CTL_UNLOCK_BIT;
  localparam logic [31:0] ENA = 32'h1 << CTL_ENABLE_BIT;
  localparam logic [31:0] ARM = 32'h1 << ALM_ARM_BIT;
  localparam logic [31:0] CHM = 32'h1 << ALM_CHIME_BIT;
  typedef struct packed {
    logic [31:0] val;
    logic [31:0] mask;
  } rar_note_t;

  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic por_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic alarm_match = 1'b0;
  logic irq;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h000112EE;
  logic [31:0] r, t, d, m, a, last_rd;
  rar_note_t exp_q[$];
  rar_note_t note;

  rar_alarm_repeat #(.HALF_SEC_CYCLES(HS)) i_rar_alarm_repeat (
    .ref_clk(ref_clk), .rst_n(rst_n), .por_n(por_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .alarm_match(alarm_match), .irq(irq));

  always #5 ref_clk = ~ref_clk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask : check

  // One bus access; the request holds until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [4:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    avs_address <= ad;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wd;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < UNSAFE_WINDOW_CYCLES)
    begin
      @(posedge ref_clk);
      n++;
    end
    last_rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= UNSAFE_WINDOW_CYCLES)
      err_count++;
    @(posedge ref_clk);
  endtask : bus

  task automatic wr(input logic [4:0] ad, input logic [31:0] wd);
    bus(1'b1, ad, wd);
  endtask : wr

  task automatic rd(input logic [4:0] ad, input logic [31:0] ev, input logic [31:0] mk);
    exp_q.push_back('{ev, mk});
    bus(1'b0, ad, 32'h0);
  endtask : rd

  // Polls read-unsafe until it shows the wanted level.
  task automatic wait_unsafe(input logic v);
    int n;
    n = 0;
    rd(ADDR_ALARM_CONTROL, 32'h0, 32'h0);
    while (last_rd[ALM_UNSAFE_BIT] !== v && n < 100)
    begin
      rd(ADDR_ALARM_CONTROL, 32'h0, 32'h0);
      n++;
    end
    check({31'h0, last_rd[ALM_UNSAFE_BIT]}, {31'h0, v});
  endtask : wait_unsafe

  task automatic alarm_wr(input logic [31:0] wd);
    wait_unsafe(1'b0);
    wr(ADDR_ALARM_CONTROL, wd);
  endtask : alarm_wr

  task automatic pulse;
    alarm_match <= 1'b1;
    @(posedge ref_clk);
    alarm_match <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : pulse

  always @(posedge ref_clk)
  begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
    begin
      if (exp_q.size() == 0)
        check(avs_readdata, 32'hXXXXXXXX);
      else
      begin
        note = exp_q.pop_front();
        if (note.mask != 32'h0)
          check(avs_readdata & note.mask, note.val & note.mask);
      end
    end
  end

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      err_count++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    @(posedge ref_clk);
    rd(ADDR_ALARM_CONTROL, 32'h0, ALL);
    rd(ADDR_IRQ_STATUS, 32'h0, ALL);
    rd(5'h1C, 32'h0, ALL);
    $display("test reset done");
    wr(ADDR_CLOCK_CONTROL, UNL);
    wr(ADDR_CLOCK_CONTROL, UNL | ENA);
    for (int i = 0; i < 6; i++)
    begin
      r = xs();
      d = {r[3:0] % 4'hA, r[7:4] % 4'hA, r[10:8], 1'b0, r[15:12] % 4'h9 + 4'h1,
           r[17:16], r[19:18] % 2'h3, r[23:20] % 4'h9 + 4'h1, r[28:24], r[31:29] % 3'h7};
      r = xs();
      t = {r[31:30], 1'b0, r[28], r[27:24] % 4'hA, r[23], r[22:20] % 3'h6,
           r[19:16] % 4'hA, r[15], r[14:12] % 3'h6, r[11:8] % 4'hA, r[7:0]};
      wr(ADDR_DATE_VALUE, d);
      rd(ADDR_DATE_VALUE, d & DATE_MASK, ALL);
      wr(ADDR_TIME_VALUE, t);
      rd(ADDR_TIME_VALUE, t & TIME_MASK, ALL);
    end
    $display("test fields done");
    wr(ADDR_CLOCK_CONTROL, ENA);
    wr(ADDR_TIME_VALUE, ~t);
    rd(ADDR_TIME_VALUE, t & TIME_MASK, ALL);
    wr(ADDR_DATE_VALUE, ~d);
    rd(ADDR_DATE_VALUE, d & DATE_MASK, ALL);
    $display("test lock done");
    wait_unsafe(1'b1);
    wait_unsafe(1'b0);
    $display("test unsafe done");
    wr(ADDR_IRQ_MASK, 32'h5);
    wr(ADDR_IRQ_STATUS, 32'h7);
    r = xs();
    m = {20'h0, r[11:8], 8'h00};
    alarm_wr(ARM | m | 32'h1);
    pulse();
    rd(ADDR_ALARM_CONTROL, ARM | m, ACMP);
    pulse();
    rd(ADDR_ALARM_CONTROL, m, ACMP);
    rd(ADDR_IRQ_STATUS, 32'h5, 32'h5);
    check({31'h0, irq}, 32'h1);
    wr(ADDR_IRQ_STATUS, 32'h5);
    repeat (2) @(posedge ref_clk);
    check({31'h0, irq}, 32'h0);
    pulse();
    rd(ADDR_IRQ_STATUS, 32'h0, 32'h5);
    check({31'h0, irq}, 32'h0);
    $display("test disarm done");
    alarm_wr(ARM | CHM);
    pulse();
    rd(ADDR_ALARM_CONTROL, ARM | CHM | 32'hFF, ACMP);
    pulse();
    rd(ADDR_ALARM_CONTROL, ARM | CHM | 32'hFE, ACMP);
    r = xs();
    a = CHM | {24'h0, r[7:0]};
    alarm_wr(a);
    pulse();
    rd(ADDR_ALARM_CONTROL, a, ACMP);
    $display("test chime done");
    wr(ADDR_CLOCK_CONTROL, ENA | UNL);
    wr(ADDR_DATE_VALUE, 32'h24123106);
    wr(ADDR_TIME_VALUE, 32'h23595900);
    repeat (2 * HS + 20) @(posedge ref_clk);
    rd(ADDR_TIME_VALUE, 32'h0, TIME_MASK);
    rd(ADDR_DATE_VALUE, 32'h25010100, DATE_MASK);
    $display("test rollover done");
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(ADDR_ALARM_CONTROL, a, ACMP);
    por_n <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    por_n <= 1'b1;
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(ADDR_ALARM_CONTROL, 32'h0, ALL);
    $display("test resets done");
    @(posedge ref_clk);
    print_verdict();
  end
endmodule : test_rar_alarm_repeat

`default_nettype wire
